// file: src/pio_defs.svh
// Register map, reset values and per-line product constants for the I/O line controller
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

`define PIO_ADDR_W 10
`define PIO_OFF_OWN_EN 10'h000
`define PIO_OFF_OWN_DIS 10'h004
`define PIO_OFF_OWN_STAT 10'h008
`define PIO_OFF_OE_EN 10'h010
`define PIO_OFF_OE_DIS 10'h014
`define PIO_OFF_OE_STAT 10'h018
`define PIO_OFF_SET_OUT 10'h030
`define PIO_OFF_CLR_OUT 10'h034
`define PIO_OFF_OUT_DATA 10'h038
`define PIO_OFF_PIN_LVL 10'h03C
`define PIO_OFF_OD_EN 10'h050
`define PIO_OFF_OD_DIS 10'h054
`define PIO_OFF_OD_STAT 10'h058
`define PIO_OFF_PU_EN 10'h060
`define PIO_OFF_PU_DIS 10'h064
`define PIO_OFF_PU_STAT 10'h068
`define PIO_OFF_SEL_A 10'h070
`define PIO_OFF_SEL_B 10'h074
`define PIO_OFF_SEL_STAT 10'h078
`define PIO_OFF_CLK_CTRL 10'h090
`define PIO_OFF_OW_EN 10'h0A0
`define PIO_OFF_OW_DIS 10'h0A4
`define PIO_OFF_OW_STAT 10'h0A8

`define PIO_ZERO 32'h0000_0000
`define PIO_RST_OE 32'h0000_0000
`define PIO_RST_OUT 32'h0000_0000
`define PIO_RST_PU 32'h0000_0000
`define PIO_RST_SEL 32'h0000_0000
`define PIO_RST_OW 32'h0000_0000
`define PIO_RST_OD 32'h0000_0000
`define PIO_RST_PIN 32'h0000_0000
`define PIO_CLK_EN_BIT 0

`define PIO_MUX_LINES 32'hFFFF_FFFF
`define PIO_RST_OWN 32'hFFFF_FFFF
`define PIO_IRQ_SOURCE 5
`define PIO_IRQ_SRC_MIN 2
`define PIO_IRQ_SRC_MAX 31

`endif

// file: src/pio_pkg.sv
// Types shared by the I/O line controller and its bench
`default_nettype none
package pio_pkg;
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } line_drive_t;
endpackage
`default_nettype wire

// file: src/parallel_io_line_controller.sv
// I/O line controller: register bank, pin drive steering and pin sampling
//
// Design decisions made here: strobed register access and the placing of the registers.
`include "pio_defs.svh"
`default_nettype none
module parallel_io_line_controller #(
  parameter logic [31:0] MUX_LINES = `PIO_MUX_LINES,
  parameter logic [31:0] OWN_RESET = `PIO_RST_OWN,
  parameter int IRQ_SOURCE = `PIO_IRQ_SOURCE
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [`PIO_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [31:0] RD_DATA,
  input wire logic [31:0] PIN_IN,
  output pio_pkg::line_drive_t PIN_DRV,
  output logic [31:0] PULLUP_EN,
  input wire pio_pkg::line_drive_t PERA_DRV,
  input wire pio_pkg::line_drive_t PERB_DRV,
  output logic [31:0] PERA_IN,
  output logic [31:0] PERB_IN,
  output logic PIO_IRQ
);

  logic [31:0] own_q;
  logic [31:0] sel_q;
  logic [31:0] pu_q;
  logic [31:0] oe_q;
  logic [31:0] out_q;
  logic [31:0] ow_q;
  logic [31:0] od_q;
  logic [31:0] pin_q;
  logic [31:0] pin_d;
  logic clk_en_q;
  logic irq_q;
  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;
  logic [31:0] drv_out;
  logic [31:0] drv_oe;

  function automatic logic hit(input logic [`PIO_ADDR_W-1:0] off);
    hit = WR_EN && (ADDR == off);
  endfunction

  // Configuration lives on the always-running bus clock, so writes never wait for sampling
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      pu_q <= `PIO_RST_PU;
    end else if (hit(`PIO_OFF_PU_EN)) begin
      pu_q <= pu_q & ~WR_DATA;
    end else if (hit(`PIO_OFF_PU_DIS)) begin
      pu_q <= pu_q | WR_DATA;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      own_q <= OWN_RESET | ~MUX_LINES;
    end else if (hit(`PIO_OFF_OWN_EN)) begin
      own_q <= own_q | WR_DATA | ~MUX_LINES;
    end else if (hit(`PIO_OFF_OWN_DIS)) begin
      own_q <= (own_q & ~WR_DATA) | ~MUX_LINES;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      sel_q <= `PIO_RST_SEL;
    end else if (hit(`PIO_OFF_SEL_A)) begin
      sel_q <= sel_q & ~WR_DATA;
    end else if (hit(`PIO_OFF_SEL_B)) begin
      sel_q <= sel_q | WR_DATA;
    end
  end

  // Kept live under peripheral ownership so the first level is ready at hand-back
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      oe_q <= `PIO_RST_OE;
    end else if (hit(`PIO_OFF_OE_EN)) begin
      oe_q <= oe_q | WR_DATA;
    end else if (hit(`PIO_OFF_OE_DIS)) begin
      oe_q <= oe_q & ~WR_DATA;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      out_q <= `PIO_RST_OUT;
    end else if (hit(`PIO_OFF_SET_OUT)) begin
      out_q <= out_q | WR_DATA;
    end else if (hit(`PIO_OFF_CLR_OUT)) begin
      out_q <= out_q & ~WR_DATA;
    end else if (hit(`PIO_OFF_OUT_DATA)) begin
      out_q <= (out_q & ~ow_q) | (WR_DATA & ow_q);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      ow_q <= `PIO_RST_OW;
    end else if (hit(`PIO_OFF_OW_EN)) begin
      ow_q <= ow_q | WR_DATA;
    end else if (hit(`PIO_OFF_OW_DIS)) begin
      ow_q <= ow_q & ~WR_DATA;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      od_q <= `PIO_RST_OD;
    end else if (hit(`PIO_OFF_OD_EN)) begin
      od_q <= od_q | WR_DATA;
    end else if (hit(`PIO_OFF_OD_DIS)) begin
      od_q <= od_q & ~WR_DATA;
    end
  end

  // Stands in for the gated peripheral clock: off after reset
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      clk_en_q <= 1'b0;
    end else if (hit(`PIO_OFF_CLK_CTRL)) begin
      clk_en_q <= WR_DATA[`PIO_CLK_EN_BIT];
    end
  end

  // While sampling is off the last captured level is held, as a stopped clock would
  assign pin_d = clk_en_q ? PIN_IN : pin_q;

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      pin_q <= `PIO_RST_PIN;
    end else begin
      pin_q <= pin_d;
    end
  end

  // Any sampled change pulses the single interrupt line; masking sits elsewhere
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= clk_en_q && (pin_d != pin_q);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_line
      always_comb begin
        logic raw_out;
        logic raw_oe;
        raw_out = 1'b0;
        raw_oe = 1'b0;
        if (own_q[g]) begin
          raw_out = out_q[g];
          raw_oe = oe_q[g];
        end else if (sel_q[g]) begin
          raw_out = PERB_DRV.out[g];
          raw_oe = PERB_DRV.oe[g];
        end else begin
          raw_out = PERA_DRV.out[g];
          raw_oe = PERA_DRV.oe[g];
        end
        // Open drain: drive only a low, release for a high
        drv_out[g] = od_q[g] ? 1'b0 : raw_out;
        drv_oe[g] = od_q[g] ? (raw_oe & ~raw_out) : raw_oe;
      end
    end
  endgenerate

  assign PIN_DRV = '{out: drv_out, oe: drv_oe};
  assign PULLUP_EN = ~pu_q;
  assign PERA_IN = PIN_IN;
  assign PERB_IN = PIN_IN;
  assign PIO_IRQ = irq_q;

  always_comb begin
    rd_data_d = `PIO_ZERO;
    if (RD_EN) begin
      unique case (ADDR)
        `PIO_OFF_OWN_STAT: rd_data_d = own_q;
        `PIO_OFF_OE_STAT: rd_data_d = oe_q;
        `PIO_OFF_OUT_DATA: rd_data_d = out_q;
        `PIO_OFF_PIN_LVL: rd_data_d = pin_q;
        `PIO_OFF_OD_STAT: rd_data_d = od_q;
        `PIO_OFF_PU_STAT: rd_data_d = pu_q;
        `PIO_OFF_SEL_STAT: rd_data_d = sel_q;
        `PIO_OFF_OW_STAT: rd_data_d = ow_q;
        `PIO_OFF_CLK_CTRL: rd_data_d = {31'h0000_0000, clk_en_q};
        default: rd_data_d = `PIO_ZERO;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      rd_data_q <= `PIO_ZERO;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign RD_DATA = rd_data_q;

  a_pullup_enable_clears: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_PU_EN) |=> ((pu_q & $past(WR_DATA)) == `PIO_ZERO))
    else $error("pull-up enable write left a status bit set");

  a_pullup_pin_sense: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (PULLUP_EN ^ pu_q) == 32'hFFFF_FFFF)
    else $error("pull-up control does not follow inverted status");

  a_reset_values: assert property (@(posedge REF_CLK)
    (!RSTN) |=> (pu_q == `PIO_ZERO && sel_q == `PIO_ZERO && ow_q == `PIO_ZERO && od_q == `PIO_ZERO && !clk_en_q))
    else $error("configuration not at reset value after reset");

  a_plain_lines_owned: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (own_q | MUX_LINES) == 32'hFFFF_FFFF)
    else $error("unmultiplexed line lost controller ownership");

  a_select_b_sets: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_SEL_B) |=> (sel_q == ($past(sel_q) | $past(WR_DATA))))
    else $error("select B write did not set select status");

  a_periph_drive_oe: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (drv_oe & ~own_q & ~od_q)
      == (((PERB_DRV.oe & sel_q) | (PERA_DRV.oe & ~sel_q)) & ~own_q & ~od_q))
    else $error("peripheral-owned pin enable not from selected peripheral");

  a_direct_write_mask: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_OUT_DATA)
      |=> (out_q == (($past(out_q) & ~$past(ow_q)) | ($past(WR_DATA) & $past(ow_q)))))
    else $error("direct data write touched a masked bit");

  a_open_drain_low: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (drv_out & od_q) == `PIO_ZERO)
    else $error("open-drain line driven high");

  a_sampling_halted: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (!clk_en_q) |=> ($stable(pin_q) && !PIO_IRQ))
    else $error("pin sampled while sampling clock off");

  a_pin_read_path: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (RD_EN && ADDR == `PIO_OFF_PIN_LVL) ##1 1'b1 |-> (RD_DATA == $past(pin_q)))
    else $error("pin level read returned wrong value");

  a_irq_source_range: assert property (@(posedge REF_CLK)
    (IRQ_SOURCE >= `PIO_IRQ_SRC_MIN) && (IRQ_SOURCE <= `PIO_IRQ_SRC_MAX))
    else $error("interrupt source number outside user range");

  a_pullup_disable_sets: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_PU_DIS) |=> (pu_q == ($past(pu_q) | $past(WR_DATA))))
    else $error("pull-up disable write did not set status");

  a_pullup_any_owner: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_PU_EN)
      |=> ((PULLUP_EN & $past(WR_DATA)) == $past(WR_DATA)))
    else $error("pull-up not switched on for a written line");

  a_own_enable_sets: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_OWN_EN)
      |=> (own_q == ($past(own_q) | $past(WR_DATA) | ~MUX_LINES)))
    else $error("ownership enable write did not set status");

  a_own_disable_clears: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_OWN_DIS)
      |=> (own_q == (($past(own_q) & ~$past(WR_DATA)) | ~MUX_LINES)))
    else $error("ownership disable write did not clear status");

  a_own_reset_value: assert property (@(posedge REF_CLK)
    (!RSTN) |=> (own_q == (OWN_RESET | ~MUX_LINES)))
    else $error("ownership status not at product reset value");

  a_select_a_clears: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_SEL_A) |=> (sel_q == ($past(sel_q) & ~$past(WR_DATA))))
    else $error("select A write did not clear select status");

  a_periph_inputs_pin: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (PERA_IN == PIN_IN) && (PERB_IN == PIN_IN))
    else $error("peripheral input does not see the pin");

  a_periph_drive_out: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (drv_out & ~own_q & ~od_q)
      == (((PERB_DRV.out & sel_q) | (PERA_DRV.out & ~sel_q)) & ~own_q & ~od_q))
    else $error("peripheral-owned pin level not from selected peripheral");

  a_own_drive_enable: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (drv_oe & own_q & ~od_q) == (oe_q & own_q & ~od_q))
    else $error("controller-owned pin enable does not follow output status");

  a_oe_enable_sets: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_OE_EN) |=> (oe_q == ($past(oe_q) | $past(WR_DATA))))
    else $error("output enable write did not set status");

  a_oe_disable_clears: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_OE_DIS) |=> (oe_q == ($past(oe_q) & ~$past(WR_DATA))))
    else $error("output disable write did not clear status");

  a_own_drive_level: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (drv_out & own_q & ~od_q) == (out_q & own_q & ~od_q))
    else $error("controller-owned pin level does not follow output data");

  a_set_out_sets: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_SET_OUT) |=> (out_q == ($past(out_q) | $past(WR_DATA))))
    else $error("set output write did not set data");

  a_clear_out_clears: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_CLR_OUT) |=> (out_q == ($past(out_q) & ~$past(WR_DATA))))
    else $error("clear output write did not clear data");

  a_preset_while_lent: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_SET_OUT)
      |=> ((out_q & ~own_q & $past(WR_DATA)) == (~own_q & $past(WR_DATA))))
    else $error("output level not preset on a peripheral-owned line");

  a_write_mask_enable: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_OW_EN) |=> (ow_q == ($past(ow_q) | $past(WR_DATA))))
    else $error("write mask enable did not set status");

  a_write_mask_disable: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_OW_DIS) |=> (ow_q == ($past(ow_q) & ~$past(WR_DATA))))
    else $error("write mask disable did not clear status");

  a_open_drain_enable: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_OD_EN) |=> (od_q == ($past(od_q) | $past(WR_DATA))))
    else $error("open-drain enable did not set status");

  a_open_drain_disable: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && ADDR == `PIO_OFF_OD_DIS) |=> (od_q == ($past(od_q) & ~$past(WR_DATA))))
    else $error("open-drain disable did not clear status");

  a_reset_quiet: assert property (@(posedge REF_CLK)
    (!RSTN) |=> (oe_q == `PIO_RST_OE && out_q == `PIO_RST_OUT && pin_q == `PIO_RST_PIN
      && !PIO_IRQ && RD_DATA == `PIO_ZERO))
    else $error("drive, sampling or read path not quiet after reset");

  a_config_no_clock: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (!clk_en_q && WR_EN && ADDR == `PIO_OFF_OE_EN)
      |=> ((oe_q & $past(WR_DATA)) == $past(WR_DATA)))
    else $error("configuration write lost while sampling clock off");

  a_zero_bits_kept: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (WR_EN && (ADDR == `PIO_OFF_PU_EN || ADDR == `PIO_OFF_PU_DIS))
      |=> ((pu_q & ~$past(WR_DATA)) == ($past(pu_q) & ~$past(WR_DATA))))
    else $error("zero bit in a set or clear write changed a status bit");

  a_irq_needs_change: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    PIO_IRQ |-> ($past(clk_en_q) && (pin_q != $past(pin_q))))
    else $error("interrupt without a sampled pin change");

  a_pin_sampled_live: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    clk_en_q |=> (pin_q == $past(PIN_IN)))
    else $error("pin level status not taken from the pin");

endmodule
`default_nettype wire

// file: test/pin_world.sv
// Pad and peripheral model facing the I/O line controller
`default_nettype none
module pin_world #(
  parameter logic [31:0] A_OUT = 32'h0000_0000,
  parameter logic [31:0] A_OE = 32'h0000_0000,
  parameter logic [31:0] B_OUT = 32'h0000_0000,
  parameter logic [31:0] B_OE = 32'h0000_0000
) (
  input wire logic clk,
  input wire pio_pkg::line_drive_t drv,
  input wire logic [31:0] pu_en,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_lvl,
  output pio_pkg::line_drive_t per_a,
  output pio_pkg::line_drive_t per_b,
  output logic [31:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] float_q = 32'h0000_0000;
  assign per_a = '{out: A_OUT, oe: A_OE};
  assign per_b = '{out: B_OUT, oe: B_OE};
  // A floating pad flips each cycle so a stale level never passes by luck
  always_ff @(posedge clk) float_q <= ~pin;
  assign pin = (drv.oe & drv.out) | (~drv.oe & ext_en & ext_lvl) | (~drv.oe & ~ext_en & (pu_en | float_q));
endmodule
`default_nettype wire

// file: test/tb.sv
// Register-level bench for the I/O line controller
`include "pio_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MUX = 32'h0FFF_FFFF;
  localparam logic [31:0] OWN_RST = 32'hFFFF_0000;
  localparam logic [31:0] PA_OUT = 32'h0000_0050;
  localparam logic [31:0] PA_OE = 32'h0000_00F0;
  localparam logic [31:0] PB_OUT = 32'h0000_00A0;
  localparam logic [31:0] PB_OE = 32'h0000_0030;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [31:0] wr_data = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data, pin_in, pullup_en, pera_in, perb_in;
  logic [31:0] ext_en = 32'hFFFF_FF80;
  logic [31:0] ext_lvl = 32'h5A5A_0000;
  logic irq;
  pio_pkg::line_drive_t pin_drv, pera_drv, perb_drv;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  parallel_io_line_controller #(.MUX_LINES(MUX), .OWN_RESET(OWN_RST)) i_parallel_io_line_controller (
    .REF_CLK(clk), .RSTN(rst_n), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en),
    .RD_DATA(rd_data), .PIN_IN(pin_in), .PIN_DRV(pin_drv), .PULLUP_EN(pullup_en), .PERA_DRV(pera_drv),
    .PERB_DRV(perb_drv), .PERA_IN(pera_in), .PERB_IN(perb_in), .PIO_IRQ(irq));

  pin_world #(.A_OUT(PA_OUT), .A_OE(PA_OE), .B_OUT(PB_OUT), .B_OE(PB_OE)) i_pin_world (
    .clk(clk), .drv(pin_drv), .pu_en(pullup_en), .ext_en(ext_en), .ext_lvl(ext_lvl),
    .per_a(pera_drv), .per_b(perb_drv), .pin(pin_in));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  task automatic complete_run;
    $display("Mismatches %0d in %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(`PIO_OFF_OWN_STAT, OWN_RST | ~MUX);
    rd(`PIO_OFF_SEL_STAT, 32'h0000_0000);
    rd(`PIO_OFF_PU_STAT, 32'h0000_0000);
    chk(pullup_en, 32'hFFFF_FFFF);
    rd(`PIO_OFF_OW_STAT, 32'h0000_0000);
    rd(`PIO_OFF_OD_STAT, 32'h0000_0000);
    rd(`PIO_OFF_PIN_LVL, 32'h0000_0000);
    rd(`PIO_OFF_OE_STAT, 32'h0000_0000);
    wr(`PIO_OFF_OWN_STAT, 32'h0000_0000);
    rd(`PIO_OFF_OWN_STAT, OWN_RST | ~MUX);
    wr(`PIO_OFF_OWN_EN, 32'hFFFF_FFFF);
    wr(`PIO_OFF_OWN_DIS, 32'hF000_00F0);
    rd(`PIO_OFF_OWN_STAT, 32'hFFFF_FF0F);
    wr(`PIO_OFF_PU_DIS, 32'h0000_00F0);
    wr(`PIO_OFF_PU_EN, 32'h0000_0030);
    rd(`PIO_OFF_PU_STAT, 32'h0000_00C0);
    chk(pullup_en, 32'hFFFF_FF3F);
    wr(`PIO_OFF_SEL_B, 32'h0000_00C0);
    wr(`PIO_OFF_SEL_A, 32'h0000_0040);
    rd(`PIO_OFF_SEL_STAT, 32'h0000_0080);
    chk(pin_drv.oe & 32'h0000_00F0, (PA_OE & 32'h0000_0070) | (PB_OE & 32'h0000_0080));
    chk(pin_drv.out & 32'h0000_00F0, (PA_OUT & 32'h0000_0070) | (PB_OUT & 32'h0000_0080));
    wr(`PIO_OFF_OE_EN, 32'h0000_00FF);
    wr(`PIO_OFF_SET_OUT, 32'h0000_00A5);
    wr(`PIO_OFF_CLR_OUT, 32'h0000_0005);
    wr(`PIO_OFF_SET_OUT, 32'h0000_0003);
    rd(`PIO_OFF_OE_STAT, 32'h0000_00FF);
    rd(`PIO_OFF_OUT_DATA, 32'h0000_00A3);
    chk(pin_drv.oe & 32'h0000_000F, 32'h0000_000F);
    chk(pin_drv.out & 32'h0000_000F, 32'h0000_0003);
    wr(`PIO_OFF_OUT_DATA, 32'hFFFF_FFFF);
    rd(`PIO_OFF_OUT_DATA, 32'h0000_00A3);
    wr(`PIO_OFF_OW_EN, 32'h0000_000F);
    wr(`PIO_OFF_OW_DIS, 32'h0000_0001);
    rd(`PIO_OFF_OW_STAT, 32'h0000_000E);
    wr(`PIO_OFF_OUT_DATA, 32'hFFFF_FFF4);
    rd(`PIO_OFF_OUT_DATA, 32'h0000_00A5);
    wr(`PIO_OFF_OD_EN, 32'h0000_0007);
    wr(`PIO_OFF_OD_DIS, 32'h0000_0004);
    rd(`PIO_OFF_OD_STAT, 32'h0000_0003);
    chk(pin_drv.oe & 32'h0000_0003, 32'h0000_0002);
    chk(pin_drv.out & 32'h0000_0002, 32'h0000_0000);
    rd(`PIO_OFF_PIN_LVL, 32'h0000_0000);
    wr(`PIO_OFF_CLK_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    rd(`PIO_OFF_PIN_LVL, 32'h5A5A_0055);
    rd(`PIO_OFF_CLK_CTRL, 32'h0000_0001);
    chk(pera_in, pin_in);
    chk(perb_in, pin_in);
    @(posedge clk);
    ext_lvl <= ext_lvl ^ 32'h0001_0000;
    @(posedge clk);
    #1;
    chk(32'(irq), 32'h0000_0001);
    @(posedge clk);
    #1;
    chk(32'(irq), 32'h0000_0000);
    wr(`PIO_OFF_CLK_CTRL, 32'h0000_0000);
    ext_lvl <= 32'h0000_0000;
    repeat (3) begin
      @(posedge clk);
      #1;
      chk(32'(irq), 32'h0000_0000);
    end
    rd(`PIO_OFF_PIN_LVL, 32'h5A5B_0055);
    complete_run();
  end
endmodule
`default_nettype wire
